// File: core/rx_buf_pkg.sv
// Constants for the serial receive buffer and its status registers
package rx_buf_pkg;
   // Register byte addresses on the APB bus
   localparam logic [7:0] ADDR_DATA = 8'h00;
   localparam logic [7:0] ADDR_STATUS_A = 8'h04;
   localparam logic [7:0] ADDR_CONTROL_B = 8'h08;
   localparam logic [7:0] ADDR_FRAME_C = 8'h0C;
   // status_reg_a bit positions
   localparam int POS_PE = 2;
   localparam int POS_OVR = 3;
   localparam int POS_FE = 4;
   localparam int POS_RXC = 7;
   // control_reg_b bit positions
   localparam int POS_NINTH = 1;
   localparam int POS_CHSZ2 = 2;
   localparam int POS_RXEN = 4;
   localparam int POS_RXCIE = 7;
   // frame_config_reg_c bit positions
   localparam int POS_CHSZ0 = 1;
   localparam int POS_STOP = 3;
   localparam int POS_PM0 = 4;
   localparam int POS_PM1 = 5;
   // Reset values
   localparam logic [7:0] RST_CONTROL_B = 8'h00;
   localparam logic [7:0] RST_FRAME_C = 8'h06;
   // FIFO depth and char size code for nine bits
   localparam int FIFO_DEPTH = 2;
   localparam logic [2:0] CHSZ_NINE = 3'h7;
   localparam logic [31:0] READ_ZERO = 32'h0000_0000;
endpackage

// File: core/usart_rx_buffer.sv
// Receive buffer, error flags and receive-complete request of a serial transceiver
`timescale 1ns/10ps
module usart_rx_buffer (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic start_detected,
   input wire logic frame_done,
   input wire logic [8:0] shift_data,
   input wire logic shift_parity,
   input wire logic shift_stop,
   input wire logic global_irq_enable,
   output logic receive_done_irq,
   output logic pin_override,
   output logic rx_active
);
   import rx_buf_pkg::*;

   typedef struct packed {
      logic [8:0] data;
      logic fe;
      logic ovr;
      logic pe;
   } entry_t;

   // Parity of the data bits that the frame really carries
   function automatic logic data_parity(input logic [8:0] d, input logic [2:0] sz);
      logic [8:0] m;
      m = 9'h000;
      unique case (sz)
         3'h0: m = 9'h01F;
         3'h1: m = 9'h03F;
         3'h2: m = 9'h07F;
         3'h3: m = 9'h0FF;
         3'h7: m = 9'h1FF;
         default: m = 9'h0FF;
      endcase
      return ^(d & m);
   endfunction

   function automatic logic [8:0] mask_data(input logic [8:0] d, input logic [2:0] sz);
      logic [8:0] r;
      r = d;
      unique case (sz)
         3'h0: r = d & 9'h01F;
         3'h1: r = d & 9'h03F;
         3'h2: r = d & 9'h07F;
         3'h7: r = d;
         default: r = d & 9'h0FF;
      endcase
      return r;
   endfunction

   entry_t fifo_q [FIFO_DEPTH];
   entry_t fifo_d [FIFO_DEPTH];
   logic [1:0] count_q, count_d;
   logic rd_ptr_q, rd_ptr_d;
   logic shift_full_q, shift_full_d;
   entry_t shift_q, shift_d;
   logic ovr_pend_q, ovr_pend_d;
   logic [7:0] control_b_q, control_b_d;
   logic [7:0] frame_c_q, frame_c_d;
   logic [31:0] prdata_q, prdata_d;
   logic pready_q, pready_d;
   logic pslverr_q, pslverr_d;
   logic irq_q, irq_d;
   logic not_empty;

   logic [2:0] char_size_field;
   logic receiver_enable_bit;
   logic parity_mode_high, parity_mode_low;
   logic setup, rd_data, wr_ctrl, wr_frame;
   entry_t head, fresh;
   logic push, pop, calc_par;
   logic wr_ptr;

   assign char_size_field = {control_b_q[POS_CHSZ2], frame_c_q[POS_CHSZ0 +: 2]};
   assign receiver_enable_bit = control_b_d[POS_RXEN];
   assign parity_mode_high = frame_c_q[POS_PM1];
   assign parity_mode_low = frame_c_q[POS_PM0];
   assign setup = psel && !penable;
   assign rd_data = setup && !pwrite && paddr == ADDR_DATA;
   assign wr_ctrl = setup && pwrite && paddr == ADDR_CONTROL_B;
   assign wr_frame = setup && pwrite && paddr == ADDR_FRAME_C;
   assign head = fifo_q[rd_ptr_q];
   assign wr_ptr = rd_ptr_q ^ count_q[0];
   assign not_empty = count_q != 2'h0;

   always_comb begin
      // Incoming frame with its own checks captured at reception
      calc_par = data_parity(shift_data, char_size_field) ^ parity_mode_low;
      fresh.data = mask_data(shift_data, char_size_field);
      fresh.fe = !shift_stop;
      fresh.pe = parity_mode_high && (calc_par != shift_parity);
      fresh.ovr = 1'b0;
   end

   // Status of the head entry, all zero while the buffer is empty
   logic head_fe, head_pe, head_ovr, head_ninth;
   assign head_fe = not_empty && head.fe;
   assign head_pe = not_empty && head.pe && parity_mode_high;
   assign head_ovr = not_empty && head.ovr;
   assign head_ninth = not_empty && head.data[8];

   // Bus writes to the two configuration registers
   always_comb begin
      control_b_d = control_b_q;
      frame_c_d = frame_c_q;
      // Only the setup cycle writes, so the access phase cannot write twice
      if (wr_ctrl) begin
         control_b_d = pwdata[7:0];
      end
      if (wr_frame) begin
         frame_c_d = pwdata[7:0];
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         control_b_q <= RST_CONTROL_B;
         frame_c_q <= RST_FRAME_C;
      end else begin
         control_b_q <= control_b_d;
         frame_c_q <= frame_c_d;
      end
   end

   // Shift register hand-over, FIFO pointers and the overrun marker
   always_comb begin
      for (int i = 0; i < FIFO_DEPTH; i++) begin
         fifo_d[i] = fifo_q[i];
      end
      count_d = count_q;
      rd_ptr_d = rd_ptr_q;
      shift_full_d = shift_full_q;
      shift_d = shift_q;
      ovr_pend_d = ovr_pend_q;
      pop = rd_data && not_empty;
      // A pop frees a slot in the same cycle, so a full buffer still takes the waiting frame
      push = shift_full_q && (count_q != 2'h2 || pop);
      if (pop) begin
         rd_ptr_d = !rd_ptr_q;
         count_d = count_d - 2'h1;
      end
      if (push) begin
         // The tail slot does not move when the head is popped in the same cycle
         fifo_d[wr_ptr] = shift_q;
         fifo_d[wr_ptr].ovr = ovr_pend_q;
         count_d = count_d + 2'h1;
         shift_full_d = 1'b0;
         ovr_pend_d = 1'b0;
      end else if (start_detected && shift_full_q) begin
         // Buffer full, a frame waiting and a new start detected: the waiting frame is lost
         ovr_pend_d = 1'b1;
         shift_full_d = 1'b0;
      end
      if (frame_done) begin
         shift_full_d = 1'b1;
         shift_d = fresh;
      end
      // Disable flushes at the edge of the write that clears the enable
      if (!receiver_enable_bit) begin
         count_d = 2'h0;
         rd_ptr_d = 1'b0;
         shift_full_d = 1'b0;
         ovr_pend_d = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         for (int i = 0; i < FIFO_DEPTH; i++) begin
            fifo_q[i] <= '0;
         end
         count_q <= 2'h0;
         rd_ptr_q <= 1'b0;
         shift_full_q <= 1'b0;
         shift_q <= '0;
         ovr_pend_q <= 1'b0;
      end else begin
         for (int i = 0; i < FIFO_DEPTH; i++) begin
            fifo_q[i] <= fifo_d[i];
         end
         count_q <= count_d;
         rd_ptr_q <= rd_ptr_d;
         shift_full_q <= shift_full_d;
         shift_q <= shift_d;
         ovr_pend_q <= ovr_pend_d;
      end
   end

   // Read data and response of the access phase
   always_comb begin
      prdata_d = READ_ZERO;
      pready_d = 1'b0;
      pslverr_d = 1'b0;
      if (setup) begin
         pready_d = 1'b1;
         unique case (paddr)
            // An empty buffer reads zero and is not popped
            ADDR_DATA: prdata_d = {24'h000000, head.data[7:0]} & {32{not_empty}};
            ADDR_STATUS_A: begin
               // Error bits are read-only; writes to them are dropped
               prdata_d[POS_RXC] = not_empty;
               prdata_d[POS_FE] = head_fe;
               prdata_d[POS_OVR] = head_ovr;
               prdata_d[POS_PE] = head_pe;
            end
            ADDR_CONTROL_B: begin
               prdata_d[7:0] = control_b_q;
               prdata_d[POS_NINTH] = head_ninth;
            end
            ADDR_FRAME_C: prdata_d[7:0] = frame_c_q;
            default: pslverr_d = 1'b1;
         endcase
         if (pwrite) begin
            prdata_d = READ_ZERO;
         end
      end
   end

   // Response stands for exactly the access cycle
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         prdata_q <= READ_ZERO;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         prdata_q <= prdata_d;
         pready_q <= pready_d;
         pslverr_q <= pslverr_d;
      end
   end

   // Request follows the buffer level; the error flags have no path to it
   always_comb begin
      irq_d = control_b_q[POS_RXCIE] && count_d != 2'h0 && global_irq_enable;
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= irq_d;
      end
   end

   // Pin hand-over follows the enable at the edge of the write that sets it
   logic override_q, override_d;
   always_comb begin
      override_d = receiver_enable_bit;
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         override_q <= 1'b0;
      end else begin
         override_q <= override_d;
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign receive_done_irq = irq_q;
   assign pin_override = override_q;
   assign rx_active = override_q;
endmodule

// File: bench/usart_rx_buffer_chk.sv
// Bus timing and request checks for the serial receive buffer
`timescale 1ns/10ps
module usart_rx_buffer_chk (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic global_irq_enable,
   input wire logic receive_done_irq,
   input wire logic pin_override,
   input wire logic rx_active
);
   import rx_buf_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   sequence s_setup;
      psel && !penable;
   endsequence
   logic mapped;
   assign mapped = paddr inside {ADDR_DATA, ADDR_STATUS_A, ADDR_CONTROL_B, ADDR_FRAME_C};
   sequence s_mapped;
      mapped;
   endsequence
   a_ready_after_setup: assert property (s_setup |=> pready)
      else $error("no ready after setup");
   a_ready_one_cycle: assert property (pready |=> !pready)
      else $error("ready held too long");
   a_err_with_ready: assert property (pslverr |-> pready)
      else $error("error without ready");
   a_err_unmapped: assert property (s_setup ##0 !mapped |=> pslverr && prdata == READ_ZERO)
      else $error("unmapped access not refused");
   a_mapped_no_err: assert property (s_setup ##0 s_mapped |=> !pslverr)
      else $error("mapped access refused");
   a_write_reads_zero: assert property ((s_setup and pwrite) |=> prdata == READ_ZERO)
      else $error("write returned data");
   a_pin_follows_enable: assert property (s_setup ##0 (pwrite && paddr == ADDR_CONTROL_B) |=>
      pin_override == $past(pwdata[POS_RXEN]) && rx_active == pin_override)
      else $error("pin override does not follow enable write");
   a_irq_needs_global: assert property (receive_done_irq |-> $past(global_irq_enable))
      else $error("request without global enable");
   a_irq_off_disabled: assert property (!rx_active [*3] |-> !receive_done_irq)
      else $error("request while disabled");
endmodule
bind usart_rx_buffer usart_rx_buffer_chk usart_rx_buffer_chk_i (.clk, .arst_n, .psel, .penable,
   .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .global_irq_enable, .receive_done_irq,
   .pin_override, .rx_active);

// File: bench/rx_front_model.sv
// Remote transmitter as seen through the receive shift register
`timescale 1ns/10ps
module rx_front_model (
   input wire logic clk,
   output logic start_detected = 1'b0,
   output logic frame_done = 1'b0,
   output logic [8:0] shift_data = 9'h000,
   output logic shift_parity = 1'b0,
   output logic shift_stop = 1'b1
);
   task automatic send(input logic [8:0] d, input logic p, input logic s);
      start_detected <= 1'b1;
      @(posedge clk);
      start_detected <= 1'b0;
      repeat (4) @(posedge clk);
      frame_done <= 1'b1;
      shift_data <= d;
      shift_parity <= p;
      shift_stop <= s;
      @(posedge clk);
      frame_done <= 1'b0;
      // Lines are stale after the pulse, so show the inverse
      shift_data <= ~d;
      shift_parity <= ~p;
      shift_stop <= ~s;
      @(posedge clk);
   endtask
endmodule

// File: bench/usart_rx_buffer_bench.sv
// Self-checking bench for the serial receive buffer
`timescale 1ns/10ps
module usart_rx_buffer_bench;
   import rx_buf_pkg::*;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic gie = 1'b1;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, v;
   logic pready, pslverr, serr, irq, pin_ov, act, st, fd, sp, ss;
   logic [8:0] sd;
   int err_total = 0;
   int cmp_count = 0;
   always #2.5 clk = ~clk;
   usart_rx_buffer usart_rx_buffer_i (.clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .start_detected(st), .frame_done(fd), .shift_data(sd),
      .shift_parity(sp), .shift_stop(ss), .global_irq_enable(gie), .receive_done_irq(irq),
      .pin_override(pin_ov), .rx_active(act));
   rx_front_model rx_front_model_i (.clk, .start_detected(st), .frame_done(fd),
      .shift_data(sd), .shift_parity(sp), .shift_stop(ss));
   task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      check("pready", 32'h1, 32'(pready));
      v = prdata;
      serr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string n);
      apb(1'b0, a, 32'h0);
      check(n, e, v);
   endtask
   task automatic t_reset();
      rdc(ADDR_CONTROL_B, 32'(RST_CONTROL_B), "ctrl");
      rdc(ADDR_FRAME_C, 32'(RST_FRAME_C), "frame");
      rdc(ADDR_STATUS_A, 32'h0, "status");
      rdc(8'h10, 32'h0, "unmapped");
      check("unmapped err", 32'h1, 32'(serr));
      $display("reset test done");
   endtask
   task automatic t_order();
      apb(1'b1, ADDR_CONTROL_B, 32'h94);
      apb(1'b1, ADDR_FRAME_C, 32'h06);
      rx_front_model_i.send(9'h1A5, 1'b0, 1'b0);
      rx_front_model_i.send(9'h03C, 1'b0, 1'b1);
      check("irq", 32'h1, 32'(irq));
      apb(1'b1, ADDR_STATUS_A, 32'h1C);
      rdc(ADDR_STATUS_A, 32'h90, "status 1");
      rdc(ADDR_CONTROL_B, 32'h96, "ninth 1");
      rdc(ADDR_DATA, 32'hA5, "data 1");
      rdc(ADDR_STATUS_A, 32'h80, "status 2");
      rdc(ADDR_CONTROL_B, 32'h94, "ninth 2");
      gie <= 1'b0;
      repeat (2) @(posedge clk);
      check("irq gated", 32'h0, 32'(irq));
      gie <= 1'b1;
      repeat (2) @(posedge clk);
      check("irq repeats", 32'h1, 32'(irq));
      rdc(ADDR_DATA, 32'h3C, "data 2");
      check("irq cleared", 32'h0, 32'(irq));
      rdc(ADDR_STATUS_A, 32'h0, "status 3");
      rdc(ADDR_DATA, 32'h0, "empty");
      $display("order test done");
   endtask
   task automatic t_parity();
      logic [7:0] d;
      apb(1'b1, ADDR_CONTROL_B, 32'h90);
      for (int m = 0; m < 4; m++) begin
         d = 8'hFF >> (3 - m);
         apb(1'b1, ADDR_FRAME_C, 32'((m << 4) | ((m & 1) << 3) | (m << 1)));
         rx_front_model_i.send(9'h1FF, ^d ^ m[0], 1'b1);
         rx_front_model_i.send(9'h1FF, ~(^d ^ m[0]), 1'b1);
         rdc(ADDR_STATUS_A, 32'h80, "parity good");
         rdc(ADDR_DATA, 32'(d), "short data");
         rdc(ADDR_STATUS_A, m > 1 ? 32'h84 : 32'h80, "parity bad");
         rdc(ADDR_DATA, 32'(d), "short data");
      end
      $display("parity test done");
   endtask
   task automatic t_overrun();
      apb(1'b1, ADDR_FRAME_C, 32'h06);
      for (int i = 0; i < 4; i++) begin
         rx_front_model_i.send(9'(i + 1), 1'b0, 1'b1);
      end
      apb(1'b1, ADDR_STATUS_A, 32'h0);
      rdc(ADDR_STATUS_A, 32'h80, "no overrun");
      rdc(ADDR_DATA, 32'h1, "first");
      rdc(ADDR_DATA, 32'h2, "second");
      rdc(ADDR_STATUS_A, 32'h88, "overrun");
      rdc(ADDR_DATA, 32'h4, "fourth");
      $display("overrun test done");
   endtask
   task automatic t_disable();
      apb(1'b1, ADDR_CONTROL_B, 32'h90);
      rx_front_model_i.send(9'h055, 1'b0, 1'b1);
      check("pin taken", 32'h1, 32'(pin_ov & act));
      rdc(ADDR_STATUS_A, 32'h80, "filled");
      apb(1'b1, ADDR_CONTROL_B, 32'h80);
      repeat (2) @(posedge clk);
      check("pin freed", 32'h0, 32'(pin_ov | act));
      check("irq off", 32'h0, 32'(irq));
      apb(1'b1, ADDR_CONTROL_B, 32'h90);
      rdc(ADDR_STATUS_A, 32'h0, "flushed");
      $display("disable test done");
   endtask
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      t_reset();
      t_order();
      t_parity();
      t_overrun();
      t_disable();
      finish_test();
   end
   initial begin
      repeat (5000) @(posedge clk);
      err_total++;
      finish_test();
   end
endmodule
